// ---- pkg/seq_pkg.sv ----
// Constants, register map and carrier types of the configuration sequencer.
// Assumes one 20 MHz system clock and an AXI4-Lite master with 32-bit data.
//
// Functional notes
// - Switch selector: 0 time, 1 frames
// - Time mode: timer restarts per entry
// - Expiry during capture holds until advance
// - Frame mode: advance after set captures
// - Count 16 bits, 1..65535, default 1
// - Rapid mode: frame advance, count one
// - First entry always captures fresh image
// - No looping: capture every entry
// - Looping: reprocess last frame, new params
// - Looping: equal camera settings skip capture
// - Looping: changed camera settings capture
// - Looping expiry: next entry, camera compared
// - Dimension selector: 0 window, 1 region
// - Region mode: dimensions select processed area
// - Region coordinates relative to full sensor
// - Window bounds all active entry regions
// - Region mode ignores user window values; the window here also bounds the active position and size
// - Region change alone is no camera change
// - One write applies all four settings
// - Save copies active config to entry
// - Load copies entry to active config
// - Query one entry, or walk all ten
package seq_pkg;

   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_COUNT  = 8'h04;
   localparam logic [7:0] OFF_CAM    = 8'h08;
   localparam logic [7:0] OFF_POS    = 8'h0c;
   localparam logic [7:0] OFF_SIZE   = 8'h10;
   localparam logic [7:0] OFF_CMD    = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_Q_CAM  = 8'h1c;
   localparam logic [7:0] OFF_Q_POS  = 8'h20;
   localparam logic [7:0] OFF_Q_SIZE = 8'h24;
   localparam logic [7:0] OFF_Q_EN   = 8'h28;
   localparam logic [7:0] OFF_WPOS   = 8'h2c;
   localparam logic [7:0] OFF_WSIZE  = 8'h30;

   localparam int CTRL_RUN  = 0;
   localparam int CTRL_SW   = 1;
   localparam int CTRL_LOOP = 2;
   localparam int CTRL_DIM  = 3;
   localparam logic [3:0]  CTRL_RST  = 4'h2;
   localparam logic [15:0] COUNT_RST = 16'h0001;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   localparam int CMD_OP_LSB = 4;
   localparam int CMD_EN_BIT = 6;
   localparam logic [1:0] OP_SAVE  = 2'h1;
   localparam logic [1:0] OP_LOAD  = 2'h2;
   localparam logic [1:0] OP_QUERY = 2'h3;
   localparam logic [3:0] IDX_ALL  = 4'hf;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int CLK_HZ        = 20_000_000;
   localparam int TICK_MS       = 1;
   localparam int CYCLES_PER_MS = CLK_HZ / 1000 * TICK_MS;

   typedef struct packed {
      logic [15:0] col;
      logic [15:0] row;
   } point_type;

   typedef struct packed {
      point_type origin;
      point_type extent;
   } win_type;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_APPLY, SEQ_CAPTURE, SEQ_RUN} seq_state_type;

endpackage : seq_pkg

// ---- logic/config_db_sequencer.sv ----
// Configuration database sequencer with its AXI4-Lite register file.
// Assumes capture_done_i and rapid_mode_i come from logic on clk_sys_i.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module config_db_sequencer #(
   parameter int ENTRIES   = 10,
   parameter int MS_CYCLES = seq_pkg::CYCLES_PER_MS
) (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_i,
   // AXI4-Lite slave
   input  wire logic [7:0]             awaddr_i,
   input  wire logic                   awvalid_i,
   output logic                        awready_o,
   input  wire logic [31:0]            wdata_i,
   input  wire logic [3:0]             wstrb_i,
   input  wire logic                   wvalid_i,
   output logic                        wready_o,
   output logic [1:0]                  bresp_o,
   output logic                        bvalid_o,
   input  wire logic                   bready_i,
   input  wire logic [7:0]             araddr_i,
   input  wire logic                   arvalid_i,
   output logic                        arready_o,
   output logic [31:0]                 rdata_o,
   output logic [1:0]                  rresp_o,
   output logic                        rvalid_o,
   input  wire logic                   rready_i,
   // Imaging pipeline
   input  wire logic                   capture_done_i,
   input  wire logic                   rapid_mode_i,
   output logic                        capture_req_o,
   output logic                        reprocess_req_o,
   output logic [3:0]                  entry_o,
   output logic [31:0]                 cam_o,
   output seq_pkg::win_type            capture_window_o
);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction : merge

   function automatic logic [15:0] far_edge(input logic [15:0] p, input logic [15:0] s);
      logic [16:0] t;
      t = {1'b0, p} + {1'b0, s};
      return t[15:0];
   endfunction : far_edge

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes
   logic [7:0]  awaddr_r;
   logic        aw_ok_r, w_ok_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rd_word;
   logic        rd_hit;

   wire wr_fire = aw_ok_r & w_ok_r & ~bvalid_r;
   wire rd_fire = arvalid_i & arready_r;
   wire wr_ctrl  = wr_fire & (awaddr_r == seq_pkg::OFF_CTRL);
   wire wr_count = wr_fire & (awaddr_r == seq_pkg::OFF_COUNT);
   wire wr_cam   = wr_fire & (awaddr_r == seq_pkg::OFF_CAM);
   wire wr_pos   = wr_fire & (awaddr_r == seq_pkg::OFF_POS);
   wire wr_size  = wr_fire & (awaddr_r == seq_pkg::OFF_SIZE);
   wire wr_cmd   = wr_fire & (awaddr_r == seq_pkg::OFF_CMD);
   wire wr_hit   = wr_ctrl | wr_count | wr_cam | wr_pos | wr_size | wr_cmd;
   wire [31:0] wr_val = merge(32'h0000_0000, wdata_r, wstrb_r);

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
         aw_ok_r  <= 1'b0;
         w_ok_r   <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r  <= seq_pkg::RESP_OKAY;
      end else begin
         if (awvalid_i & awready_r) begin
            awaddr_r  <= awaddr_i;
            aw_ok_r   <= 1'b1;
            awready_r <= 1'b0;
         end
         if (wvalid_i & wready_r) begin
            wdata_r  <= wdata_i;
            wstrb_r  <= wstrb_i;
            w_ok_r   <= 1'b1;
            wready_r <= 1'b0;
         end
         if (wr_fire) begin
            aw_ok_r  <= 1'b0;
            w_ok_r   <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
         end else if (bvalid_r & bready_i) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= seq_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_word;
         rresp_r   <= rd_hit ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
      end else if (rvalid_r & rready_i) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Active settings and database
   logic [3:0]  ctrl_r;
   logic [15:0] count_r;
   logic [31:0] cam_r, pos_r, size_r;
   logic [31:0] db_cam [ENTRIES];
   logic [31:0] db_pos [ENTRIES];
   logic [31:0] db_size[ENTRIES];
   logic        db_en  [ENTRIES];
   logic [3:0]  q_idx_r;
   logic        q_all_r;
   seq_pkg::seq_state_type state_r;
   logic [3:0]  cur_r;

   wire [3:0] cmd_idx = wr_val[3:0];
   wire [1:0] cmd_op  = wr_val[seq_pkg::CMD_OP_LSB +: 2];
   wire idx_ok    = 32'(cmd_idx) < ENTRIES;
   wire do_save   = wr_cmd & (cmd_op == seq_pkg::OP_SAVE) & idx_ok;
   wire do_load   = wr_cmd & (cmd_op == seq_pkg::OP_LOAD) & idx_ok;
   wire do_query  = wr_cmd & (cmd_op == seq_pkg::OP_QUERY);
   wire applying  = state_r == seq_pkg::SEQ_APPLY;
   wire q_step    = rd_fire & (araddr_i == seq_pkg::OFF_Q_SIZE) & q_all_r;
   wire frame_md  = rapid_mode_i | ctrl_r[seq_pkg::CTRL_SW];
   wire [15:0] limit = rapid_mode_i ? seq_pkg::COUNT_ONE : count_r;
   wire looping   = ctrl_r[seq_pkg::CTRL_LOOP];
   wire region_md = ctrl_r[seq_pkg::CTRL_DIM];

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_r  <= seq_pkg::CTRL_RST;
         count_r <= seq_pkg::COUNT_RST;
         cam_r   <= 32'h0000_0000;
         pos_r   <= 32'h0000_0000;
         size_r  <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) ctrl_r <= wr_val[3:0];
         if (wr_count & (wr_val[15:0] != 16'h0000)) count_r <= wr_val[15:0];
         if (applying) begin
            cam_r  <= db_cam[cur_r];
            pos_r  <= db_pos[cur_r];
            size_r <= db_size[cur_r];
         end else if (do_load) begin
            cam_r  <= db_cam[cmd_idx];
            pos_r  <= db_pos[cmd_idx];
            size_r <= db_size[cmd_idx];
         end else begin
            if (wr_cam)  cam_r  <= wr_val;
            if (wr_pos)  pos_r  <= wr_val;
            if (wr_size) size_r <= wr_val;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         for (int e = 0; e < ENTRIES; e++) begin
            db_cam[e]  <= 32'h0000_0000;
            db_pos[e]  <= 32'h0000_0000;
            db_size[e] <= 32'h0000_0000;
            db_en[e]   <= 1'b0;
         end
         q_idx_r <= 4'h0;
         q_all_r <= 1'b0;
      end else begin
         if (do_save) begin
            db_cam[cmd_idx]  <= cam_r;
            db_pos[cmd_idx]  <= pos_r;
            db_size[cmd_idx] <= size_r;
            db_en[cmd_idx]   <= wr_val[seq_pkg::CMD_EN_BIT];
         end
         if (do_query) begin
            q_all_r <= cmd_idx == seq_pkg::IDX_ALL;
            q_idx_r <= (cmd_idx == seq_pkg::IDX_ALL) | ~idx_ok ? 4'h0 : cmd_idx;
         end else if (q_step) begin
            q_idx_r <= 32'(q_idx_r) == ENTRIES - 1 ? 4'h0 : q_idx_r + 4'h1;
            q_all_r <= 32'(q_idx_r) != ENTRIES - 1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Entry sequencing
   logic [31:0] last_cam_r;
   logic [15:0] frames_r, ms_r;
   logic [31:0] pre_r;
   logic        expired_r, cap_r, rep_r;
   logic [3:0]  nxt_entry;

   wire first     = cur_r == 4'h0;
   wire cam_diff  = db_cam[cur_r] != last_cam_r;
   wire need_cap  = first | ~looping | cam_diff;
   wire count_hit = frame_md & (frames_r >= limit);
   wire time_hit  = ~frame_md & expired_r;
   wire run_on    = ctrl_r[seq_pkg::CTRL_RUN];

   always_comb begin
      nxt_entry = 4'h0;
      for (int e = ENTRIES - 1; e > 0; e--) begin
         if (e > 32'(cur_r) && db_en[e]) nxt_entry = 4'(e);
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_r    <= seq_pkg::SEQ_IDLE;
         cur_r      <= 4'h0;
         last_cam_r <= 32'h0000_0000;
         frames_r   <= 16'h0000;
         cap_r      <= 1'b0;
         rep_r      <= 1'b0;
      end else begin
         cap_r <= 1'b0;
         rep_r <= 1'b0;
         case (state_r)
            seq_pkg::SEQ_IDLE: begin
               cur_r <= 4'h0;
               if (run_on) state_r <= seq_pkg::SEQ_APPLY;
            end
            seq_pkg::SEQ_APPLY: begin
               if (need_cap) begin
                  cap_r      <= 1'b1;
                  last_cam_r <= db_cam[cur_r];
                  frames_r   <= 16'h0000;
                  state_r    <= seq_pkg::SEQ_CAPTURE;
               end else begin
                  rep_r    <= 1'b1;
                  frames_r <= seq_pkg::COUNT_ONE;
                  state_r  <= seq_pkg::SEQ_RUN;
               end
            end
            seq_pkg::SEQ_CAPTURE: begin
               if (capture_done_i) begin
                  frames_r <= frames_r + 16'h0001;
                  state_r  <= seq_pkg::SEQ_RUN;
               end
            end
            seq_pkg::SEQ_RUN: begin
               if (!run_on) begin
                  state_r <= seq_pkg::SEQ_IDLE;
               end else if (count_hit | time_hit) begin
                  cur_r   <= nxt_entry;
                  state_r <= seq_pkg::SEQ_APPLY;
               end else if (frame_md) begin
                  cap_r      <= 1'b1;
                  last_cam_r <= cam_r;
                  state_r    <= seq_pkg::SEQ_CAPTURE;
               end
            end
            default: state_r <= seq_pkg::SEQ_IDLE;
         endcase
      end
   end

   // Interval timer: a held expiry waits for the next apply, which restarts it
   wire timing = (state_r == seq_pkg::SEQ_CAPTURE) | (state_r == seq_pkg::SEQ_RUN);
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         pre_r     <= 32'h0000_0000;
         ms_r      <= 16'h0000;
         expired_r <= 1'b0;
      end else if (applying | ~timing) begin
         pre_r     <= 32'h0000_0000;
         ms_r      <= 16'h0000;
         expired_r <= 1'b0;
      end else if (!expired_r) begin
         pre_r <= (pre_r == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : pre_r + 32'h1;
         if (pre_r == 32'(MS_CYCLES - 1)) begin
            ms_r      <= ms_r + 16'h0001;
            expired_r <= ms_r + 16'h0001 >= count_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture window
   seq_pkg::win_type win_nxt, win_r;
   logic [15:0] r0, c0, r1, c1;

   always_comb begin
      r0 = pos_r[15:0];
      c0 = pos_r[31:16];
      r1 = far_edge(pos_r[15:0], size_r[15:0]);
      c1 = far_edge(pos_r[31:16], size_r[31:16]);
      for (int e = 0; e < ENTRIES; e++) begin
         if (e == 0 || db_en[e]) begin
            if (db_pos[e][15:0] < r0)  r0 = db_pos[e][15:0];
            if (db_pos[e][31:16] < c0) c0 = db_pos[e][31:16];
            if (far_edge(db_pos[e][15:0], db_size[e][15:0]) > r1)
               r1 = far_edge(db_pos[e][15:0], db_size[e][15:0]);
            if (far_edge(db_pos[e][31:16], db_size[e][31:16]) > c1)
               c1 = far_edge(db_pos[e][31:16], db_size[e][31:16]);
         end
      end
      if (region_md) begin
         win_nxt = {c0, r0, 16'(c1 - c0), 16'(r1 - r0)};
      end else begin
         win_nxt = {pos_r, size_r};
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) win_r <= '0;
      else         win_r <= win_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (araddr_i)
         seq_pkg::OFF_CTRL:   rd_word = {28'h0, ctrl_r};
         seq_pkg::OFF_COUNT:  rd_word = {16'h0, count_r};
         seq_pkg::OFF_CAM:    rd_word = cam_r;
         seq_pkg::OFF_POS:    rd_word = pos_r;
         seq_pkg::OFF_SIZE:   rd_word = size_r;
         seq_pkg::OFF_CMD:    rd_word = 32'h0000_0000;
         seq_pkg::OFF_STATUS: rd_word = {24'h0, state_r, expired_r, q_all_r, cur_r};
         seq_pkg::OFF_Q_CAM:  rd_word = db_cam[q_idx_r];
         seq_pkg::OFF_Q_POS:  rd_word = db_pos[q_idx_r];
         seq_pkg::OFF_Q_SIZE: rd_word = db_size[q_idx_r];
         seq_pkg::OFF_Q_EN:   rd_word = {27'h0, db_en[q_idx_r], q_idx_r};
         seq_pkg::OFF_WPOS:   rd_word = win_r.origin;
         seq_pkg::OFF_WSIZE:  rd_word = win_r.extent;
         default:             rd_hit  = 1'b0;
      endcase
   end

   assign awready_o        = awready_r;
   assign wready_o         = wready_r;
   assign bvalid_o         = bvalid_r;
   assign bresp_o          = bresp_r;
   assign arready_o        = arready_r;
   assign rvalid_o         = rvalid_r;
   assign rdata_o          = rdata_r;
   assign rresp_o          = rresp_r;
   assign capture_req_o    = cap_r;
   assign reprocess_req_o  = rep_r;
   assign entry_o          = cur_r;
   assign cam_o            = cam_r;
   assign capture_window_o = win_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   a_first_entry_capture: assert property (applying && first |=> cap_r && !rep_r)
      else $error("First entry did not capture");
   a_noloop_capture: assert property (applying && !looping |=> cap_r)
      else $error("Capture skipped with looping off");
   a_loop_skip: assert property (applying && looping && !first && !cam_diff
      |=> rep_r && !cap_r && state_r == seq_pkg::SEQ_RUN)
      else $error("Unchanged camera entry was captured");
   a_loop_change_cap: assert property (applying && looping && cam_diff |=> cap_r)
      else $error("Changed camera entry not captured");
   a_timer_hold: assert property (state_r == seq_pkg::SEQ_CAPTURE && expired_r
      && !capture_done_i |=> state_r == seq_pkg::SEQ_CAPTURE && expired_r)
      else $error("Expired timer left capture early");
   a_frame_advance: assert property (state_r == seq_pkg::SEQ_RUN && run_on
      && frame_md && frames_r >= limit |=> applying && cur_r == $past(nxt_entry))
      else $error("Frame count reached without advance");
   a_rapid_one: assert property (rapid_mode_i && state_r == seq_pkg::SEQ_CAPTURE
      && capture_done_i ##1 rapid_mode_i && run_on |=> applying)
      else $error("Rapid mode did not advance after one frame");
   a_count_nonzero: assert property (count_r != 16'h0000)
      else $error("Interval count reached zero");
   a_write_answer: assert property (wr_fire |=> bvalid_r ##0 bvalid_r[*1])
      else $error("Write response missing");

   c_fresh_capture: cover property (cap_r ##[1:20] capture_done_i);
   c_reprocess: cover property (rep_r);
   c_time_advance: cover property (time_hit && state_r == seq_pkg::SEQ_RUN ##1 applying);
   c_wrap_first: cover property (applying && !first ##[1:40] applying && first);

endmodule : config_db_sequencer

// ---- sim/capture_pipe_model.sv ----
// Imaging pipeline stand-in: answers each capture request with a done pulse.
// Assumes requests are single-cycle pulses on the system clock.
`timescale 1ns/1ps
module capture_pipe_model #(
   parameter int DELAY = 3
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   // Pipeline handshake
   input  wire logic capture_req_i,
   output logic      capture_done_o
);
   int cnt_r;
   // Exposure takes a few cycles, so done never lands in the request cycle
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r          <= 0;
         capture_done_o <= 1'b0;
      end else begin
         capture_done_o <= (cnt_r == 1);
         if (capture_req_i) cnt_r <= DELAY;
         else if (cnt_r != 0) cnt_r <= cnt_r - 1;
      end
   end
endmodule : capture_pipe_model

// ---- sim/config_database_sequencer_tb.sv ----
// Self-checking bench: AXI4-Lite tasks plus a pipeline model on the far side.
// Assumes the register map and reset values of seq_pkg.
`timescale 1ns/1ps
module config_database_sequencer_tb;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, done, rapid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb, entry;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, cap, rep;
   logic [4:0]  ev[$];
   logic [31:0] cam;
   seq_pkg::win_type win;
   int          n_mismatch, n_tests;
   ////////////////////////////////////////////////////////////////////////////
   config_db_sequencer #(.MS_CYCLES(4)) u_config_db_sequencer (
      .clk_sys_i(clk), .reset_i(rst), .awaddr_i(awaddr), .awvalid_i(awvalid),
      .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
      .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
      .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
      .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .capture_done_i(done),
      .rapid_mode_i(rapid), .capture_req_o(cap), .reprocess_req_o(rep),
      .entry_o(entry), .cam_o(cam), .capture_window_o(win));
   // A slow capture lets the interval timer run out while the frame is still pending
   capture_pipe_model #(.DELAY(6)) u_capture_pipe_model (
      .clk_sys_i(clk), .reset_i(rst), .capture_req_i(cap), .capture_done_o(done));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Sampled off the edge, so a one-cycle pulse is never missed or raced
   always @(negedge clk) if (!rst) begin
      if (cap) ev.push_back({1'b0, entry});
      if (rep) ev.push_back({1'b1, entry});
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic timeout();
      n_mismatch++;
      $display("ERROR timeout expected answer seen none");
      end_sim();
   endtask : timeout
   // Handshake state is judged at the falling edge, acted on at the next rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            chk("bresp", {30'h0, r}, {30'h0, seq_pkg::RESP_OKAY});
            return;
         end
      end
      timeout();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         ta = arvalid & arready; tr = rvalid; d = rdata; r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            return;
         end
      end
      timeout();
   endtask : rd
   // Start the sequencer, check three capture/reprocess events, then park it in idle
   task automatic run(input logic [31:0] c, input logic [4:0] e0, e1, e2);
      wr(seq_pkg::OFF_CTRL, c);
      for (int n = 0; n < 500 && ev.size() < 3; n++) @(posedge clk);
      if (ev.size() < 3) timeout();
      chk("event 0", {27'h0, ev[0]}, {27'h0, e0});
      chk("event 1", {27'h0, ev[1]}, {27'h0, e1});
      chk("event 2", {27'h0, ev[2]}, {27'h0, e2});
      wr(seq_pkg::OFF_CTRL, c & 32'hffff_fffe);
      repeat (40) @(posedge clk);
      ev.delete();
   endtask : run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; rapid = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'hf; n_mismatch = 0; n_tests = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(seq_pkg::OFF_CTRL); chk("ctrl", d, 32'h2);
      rd(seq_pkg::OFF_COUNT); chk("count", d, 32'h1);
      wr(seq_pkg::OFF_COUNT, 32'h0);
      rd(seq_pkg::OFF_COUNT); chk("count zero", d, 32'h1);
      rd(8'h3c); chk("unmapped", {30'h0, r}, {30'h0, seq_pkg::RESP_SLVERR});
      // Entries 0 and 1 share one camera word, so with looping on entry 1 must not recapture
      wr(seq_pkg::OFF_CAM, 32'h0000_00aa);
      wr(seq_pkg::OFF_CMD, 32'h50);
      wr(seq_pkg::OFF_POS, 32'h0000_0008);
      wr(seq_pkg::OFF_CMD, 32'h51);
      wr(seq_pkg::OFF_CAM, 32'h0000_00bb);
      wr(seq_pkg::OFF_CMD, 32'h21);
      rd(seq_pkg::OFF_CAM); chk("load cam", d, 32'h0000_00aa);
      wr(seq_pkg::OFF_CMD, 32'h31);
      rd(seq_pkg::OFF_Q_CAM); chk("query cam", d, 32'h0000_00aa);
      run(32'h7, 5'h00, 5'h11, 5'h00);
      run(32'h3, 5'h00, 5'h01, 5'h00);
      wr(seq_pkg::OFF_POS, 32'h0010_0020);
      wr(seq_pkg::OFF_SIZE, 32'h0030_0040);
      wr(seq_pkg::OFF_CAM, 32'h0000_00cc);
      wr(seq_pkg::OFF_CMD, 32'h52);
      run(32'h7, 5'h00, 5'h11, 5'h02);
      wr(seq_pkg::OFF_COUNT, 32'h2);
      run(32'h3, 5'h00, 5'h00, 5'h01);
      rapid <= 1'b1;
      run(32'h3, 5'h00, 5'h01, 5'h02);
      rapid <= 1'b0;
      wr(seq_pkg::OFF_COUNT, 32'h1);
      run(32'h5, 5'h00, 5'h11, 5'h02);
      wr(seq_pkg::OFF_CMD, 32'h22);
      rd(seq_pkg::OFF_CAM); chk("load cam 2", d, 32'h0000_00cc);
      chk("cam port", cam, 32'h0000_00cc);
      rd(seq_pkg::OFF_WPOS); chk("window pos", d, 32'h0010_0020);
      wr(seq_pkg::OFF_CTRL, 32'h8);
      rd(seq_pkg::OFF_WPOS); chk("region pos", d, 32'h0);
      rd(seq_pkg::OFF_WSIZE); chk("region size", d, 32'h0040_0060);
      chk("window port", win.extent, 32'h0040_0060);
      wr(seq_pkg::OFF_CMD, 32'h3f);
      rd(seq_pkg::OFF_Q_SIZE);
      rd(seq_pkg::OFF_Q_EN); chk("query walk", d, 32'h11);
      end_sim();
   end
endmodule : config_database_sequencer_tb
